// ---- hw/trc_pkg.sv ----
// constants and types for the terminal run command decoder
// assumes a single 100 MHz control clock
package trc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  // filter time counts in units of this tick
  localparam int FILT_TICK_NS = 1_000_000;
  localparam int FILT_TICK_CYCLES = FILT_TICK_NS / CLK_PERIOD_NS;
  localparam logic [9:0] FILT_TIME_DFLT_MS = 10'h00A;
  // terminal indices in the raw and filtered vectors
  localparam int NUM_TERMS = 5;
  localparam int TERM_ONE = 0;
  localparam int TERM_TWO = 1;
  localparam int TERM_THREE = 2;
  localparam int TERM_UP = 3;
  localparam int TERM_DOWN = 4;
  // command schemes
  typedef enum logic [1:0] {
    TRC_TWO_WIRE_A = 2'h0,
    TRC_TWO_WIRE_B = 2'h1,
    TRC_THREE_WIRE_A = 2'h2,
    TRC_THREE_WIRE_B = 2'h3
  } trc_scheme_t;
  localparam trc_scheme_t SCHEME_DFLT = TRC_TWO_WIRE_A;
  // up/down rate: units of the resolution per second
  localparam logic [1:0] RES_CENTI = 2'h1;
  localparam logic [1:0] RES_MILLI = 2'h2;
  localparam logic [4:0] STEP_CENTI_MHZ = 5'h0A;
  localparam logic [4:0] STEP_MILLI_MHZ = 5'h01;
  localparam logic [15:0] UD_RATE_DFLT_CENTI = 16'h0064;
  localparam logic [15:0] UD_RATE_DFLT_MILLI = 16'h03E8;
  localparam logic [26:0] UD_ACC_WRAP = 27'h5F5E100;
  // analog curve, volts in 0.01 V, settings in 0.1 % signed
  localparam logic [9:0] CURVE_MIN_IN_DFLT = 10'h000;
  localparam logic [9:0] CURVE_MAX_IN_DFLT = 10'h3E8;
  localparam logic signed [10:0] CURVE_MIN_SET_DFLT = 11'sh000;
  localparam logic signed [10:0] CURVE_MAX_SET_DFLT = 11'sh3E8;
  localparam logic [3:0] BELOW_MIN_USE_MIN = 4'h0;
  localparam logic [3:0] BELOW_MIN_USE_ZERO = 4'h1;
  localparam logic [4:0] DIV_STEPS = 5'h15;
  typedef enum logic [1:0] {
    TRC_AN_IDLE = 2'b00,
    TRC_AN_DIV = 2'b01,
    TRC_AN_DONE = 2'b11
  } trc_an_state_t;
endpackage

// ---- hw/trc_top.sv ----
// terminal run command decoder: filter, schemes, up/down ramp, analog curve
// assumes terminal inputs synchronous to mclk, config held steady by software
// Notes on behaviour
// RULE1: every terminal passes a debounce filter of configurable time before use.
// RULE2: scheme select 0..3 picks two-wire A/B, three-wire A/B; default 0.
// RULE3: two-wire A: one alone forward, two alone reverse, else stop.
// RULE4: two-wire B: one enables run, two high selects reverse.
// RULE5: three-wire A: three is enable, one forward, two reverse.
// RULE6: three-wire A: button press starts that direction; state held after release.
// RULE7: three-wire: enable inactive stops at once regardless of others.
// RULE8: three-wire: latest button event decides running state.
// RULE9: operator keeps enable active while running; release means stop.
// RULE10: three-wire B: three enable, one momentary run, two direction level.
// RULE11: three-wire B: run press starts; direction follows input two level.
// RULE12: up/down terminals ramp frequency at configurable rate, default 1.00 Hz/s.
// RULE13: rate units follow resolution select: 1 gives 0.01, 2 gives 0.001 Hz/s.
// RULE14: analog input one maps linearly between min and max curve points.
// RULE15: input above max point gives the max point setting.
// RULE16: input below min point gives the below-minimum selector's value.
// RULE17: below-minimum selector 0 gives min setting, 1 gives zero.
// RULE18: current input converts at 0.5 V per mA before the curve.
// RULE19: filter accepts a level only after it stays stable for the time.
// RULE20: three-wire buttons act on the filtered rising edge only.
`timescale 1ns/1ns
`default_nettype none
module trc_top #(
  parameter int TICK_CYCLES = trc_pkg::FILT_TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // raw terminals
  input wire logic input_term_one,
  input wire logic input_term_two,
  input wire logic input_term_three,
  input wire logic up_term,
  input wire logic down_term,
  // configuration
  input wire logic [9:0] terminal_filter_time,
  input wire trc_pkg::trc_scheme_t terminal_scheme_select,
  input wire logic [15:0] updown_rate,
  input wire logic [1:0] freq_resolution_select,
  input wire logic [19:0] updown_limit,
  input wire logic [10:0] analog_input_one,
  input wire logic analog_is_current,
  input wire logic [9:0] curve_min_input,
  input wire logic signed [10:0] curve_min_setting,
  input wire logic [9:0] curve_max_input,
  input wire logic signed [10:0] curve_max_setting,
  input wire logic [3:0] below_min_handling,
  // results
  output logic [4:0] filtered_terms,
  output logic forward_run_cmd,
  output logic reverse_run_cmd,
  output logic [19:0] updown_freq,
  output logic signed [10:0] analog_setting
);
  import trc_pkg::*;

  // filter time base
  logic [16:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 17'h00001;
    if (tick_cnt_q == 17'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 17'h00000;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 17'h00000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  logic [4:0] raw;
  logic [4:0] filt_q;
  assign raw = {down_term, up_term, input_term_three, input_term_two,
                input_term_one};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERMS; gi++) begin : g_filt
      logic last_q, last_d, f_d;
      logic [9:0] cnt_q, cnt_d;
      always_comb begin
        last_d = raw[gi];
        f_d = filt_q[gi];
        cnt_d = cnt_q;
        if (raw[gi] != last_q) begin
          cnt_d = 10'h000; // RULE19
        end else if (last_q != filt_q[gi]) begin
          if (cnt_q > terminal_filter_time || ~|terminal_filter_time) begin
            f_d = last_q; // RULE1
            cnt_d = 10'h000;
          end else if (tick_q) begin
            cnt_d = cnt_q + 10'h001;
          end
        end else begin
          cnt_d = 10'h000;
        end
      end
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          last_q <= 1'b0;
          filt_q[gi] <= 1'b0;
          cnt_q <= 10'h000;
        end else begin
          last_q <= last_d;
          filt_q[gi] <= f_d;
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate

  // run command decode
  logic prev_one_q, prev_two_q;
  logic run_q, run_d, rev_q, rev_d;
  logic fwd_cmd_d, rev_cmd_d;
  logic t1, t2, t3, rise1, rise2;
  assign t1 = filt_q[TERM_ONE];
  assign t2 = filt_q[TERM_TWO];
  assign t3 = filt_q[TERM_THREE];
  assign rise1 = t1 && !prev_one_q; // RULE20
  assign rise2 = t2 && !prev_two_q; // RULE20
  always_comb begin
    run_d = run_q;
    rev_d = rev_q;
    fwd_cmd_d = 1'b0;
    rev_cmd_d = 1'b0;
    case (terminal_scheme_select) // RULE2
      TRC_TWO_WIRE_A: begin
        run_d = 1'b0;
        fwd_cmd_d = t1 && !t2; // RULE3
        rev_cmd_d = t2 && !t1; // RULE3
      end
      TRC_TWO_WIRE_B: begin
        run_d = 1'b0;
        fwd_cmd_d = t1 && !t2; // RULE4
        rev_cmd_d = t1 && t2; // RULE4
      end
      TRC_THREE_WIRE_A: begin
        if (!t3) begin
          run_d = 1'b0; // RULE7 RULE9
        end else if (rise1 && rise2) begin
          run_d = 1'b0;
        end else if (rise1) begin
          run_d = 1'b1; // RULE5 RULE6 RULE8
          rev_d = 1'b0;
        end else if (rise2) begin
          run_d = 1'b1; // RULE5 RULE6 RULE8
          rev_d = 1'b1;
        end
        fwd_cmd_d = t3 && run_d && !rev_d;
        rev_cmd_d = t3 && run_d && rev_d;
      end
      TRC_THREE_WIRE_B: begin
        if (!t3) begin
          run_d = 1'b0; // RULE7
        end else if (rise1) begin
          run_d = 1'b1; // RULE10 RULE11 RULE8
        end
        rev_d = t2; // RULE11
        fwd_cmd_d = t3 && run_d && !t2;
        rev_cmd_d = t3 && run_d && t2;
      end
      default: begin
        run_d = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_one_q <= 1'b0;
      prev_two_q <= 1'b0;
      run_q <= 1'b0;
      rev_q <= 1'b0;
      forward_run_cmd <= 1'b0;
      reverse_run_cmd <= 1'b0;
      filtered_terms <= 5'h00;
    end else begin
      prev_one_q <= t1;
      prev_two_q <= t2;
      run_q <= run_d;
      rev_q <= rev_d;
      forward_run_cmd <= fwd_cmd_d;
      reverse_run_cmd <= rev_cmd_d;
      filtered_terms <= filt_q;
    end
  end

  // up/down ramp, one step per wrap of the rate accumulator
  logic [26:0] acc_q, acc_d;
  logic [19:0] freq_d;
  logic [15:0] rate;
  logic [4:0] step;
  logic [20:0] sum;
  logic up, dn;
  assign up = filt_q[TERM_UP] && !filt_q[TERM_DOWN];
  assign dn = filt_q[TERM_DOWN] && !filt_q[TERM_UP];
  always_comb begin
    if (freq_resolution_select == RES_MILLI) begin
      step = STEP_MILLI_MHZ; // RULE13
      rate = (updown_rate == 16'h0000) ? UD_RATE_DFLT_MILLI : updown_rate;
    end else begin
      step = STEP_CENTI_MHZ; // RULE13
      rate = (updown_rate == 16'h0000) ? UD_RATE_DFLT_CENTI : updown_rate;
    end
    acc_d = 27'h0000000;
    freq_d = updown_freq;
    sum = 21'h000000;
    if (up || dn) begin
      acc_d = acc_q + 27'(rate); // RULE12
      if (acc_d >= UD_ACC_WRAP) begin
        acc_d = acc_d - UD_ACC_WRAP;
        if (up) begin
          sum = {1'b0, updown_freq} + 21'(step);
          freq_d = (sum > {1'b0, updown_limit}) ? updown_limit : sum[19:0];
        end else begin
          freq_d = (updown_freq > 20'(step)) ?
                   updown_freq - 20'(step) : 20'h00000;
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= 27'h0000000;
      updown_freq <= 20'h00000;
    end else begin
      acc_q <= acc_d;
      updown_freq <= freq_d;
    end
  end

  // analog curve with serial divider
  trc_an_state_t st_q, st_d;
  logic [9:0] volt;
  logic [10:0] dv;
  logic signed [11:0] ds;
  logic [10:0] ds_mag;
  logic [20:0] num_q, num_d, quo_q, quo_d;
  logic [10:0] rem_q, rem_d, rem_s;
  logic [9:0] den_q, den_d;
  logic neg_q, neg_d;
  logic signed [10:0] smin_q, smin_d, out_d;
  logic [4:0] cnt_q, cnt_d;
  logic signed [12:0] res;
  assign volt = analog_is_current ? analog_input_one[10:1] // RULE18
                                  : analog_input_one[9:0];
  assign dv = {1'b0, volt} - {1'b0, curve_min_input};
  assign ds = 12'(curve_max_setting) - 12'(curve_min_setting);
  assign ds_mag = ds[11] ? 11'(-ds) : ds[10:0];
  assign rem_s = {rem_q[9:0], num_q[20]};
  always_comb begin
    st_d = st_q;
    num_d = num_q;
    quo_d = quo_q;
    rem_d = rem_q;
    den_d = den_q;
    neg_d = neg_q;
    smin_d = smin_q;
    cnt_d = cnt_q;
    out_d = analog_setting;
    res = 13'sh0000;
    case (st_q)
      TRC_AN_IDLE: begin
        if (volt > curve_max_input ||
            curve_max_input <= curve_min_input) begin
          out_d = curve_max_setting; // RULE15
        end else if (volt < curve_min_input) begin
          out_d = (below_min_handling == BELOW_MIN_USE_ZERO) ? // RULE16
                  11'sh000 : curve_min_setting; // RULE17
        end else begin
          num_d = 21'(dv[9:0]) * 21'(ds_mag); // RULE14
          den_d = curve_max_input - curve_min_input;
          neg_d = ds[11];
          smin_d = curve_min_setting;
          quo_d = 21'h000000;
          rem_d = 11'h000;
          cnt_d = 5'h00;
          st_d = TRC_AN_DIV;
        end
      end
      TRC_AN_DIV: begin
        num_d = {num_q[19:0], 1'b0};
        if (rem_s >= {1'b0, den_q}) begin
          rem_d = rem_s - {1'b0, den_q};
          quo_d = {quo_q[19:0], 1'b1};
        end else begin
          rem_d = rem_s;
          quo_d = {quo_q[19:0], 1'b0};
        end
        cnt_d = cnt_q + 5'h01;
        if (cnt_d == DIV_STEPS) begin
          st_d = TRC_AN_DONE;
        end
      end
      TRC_AN_DONE: begin
        res = neg_q ? 13'(smin_q) - 13'(quo_q[11:0])
                    : 13'(smin_q) + 13'(quo_q[11:0]);
        out_d = res[10:0]; // RULE14
        st_d = TRC_AN_IDLE;
      end
      default: begin
        st_d = TRC_AN_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= TRC_AN_IDLE;
      num_q <= 21'h000000;
      quo_q <= 21'h000000;
      rem_q <= 11'h000;
      den_q <= 10'h000;
      neg_q <= 1'b0;
      smin_q <= 11'sh000;
      cnt_q <= 5'h00;
      analog_setting <= 11'sh000;
    end else begin
      st_q <= st_d;
      num_q <= num_d;
      quo_q <= quo_d;
      rem_q <= rem_d;
      den_q <= den_d;
      neg_q <= neg_d;
      smin_q <= smin_d;
      cnt_q <= cnt_d;
      analog_setting <= out_d;
    end
  end
endmodule // trc_top
`default_nettype wire

// ---- hw/trc_unused_none.sv ----
// intentionally empty companion: no additional logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- testbench/trc_operator.sv ----
// operator contacts: every change of a contact bounces, then settles
// one clock; wanted contact levels come from the bench
`timescale 1ns/1ns
`default_nettype none
module trc_operator (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // wanted levels, {down,up,three,two,one}
  input wire logic [4:0] want,
  // contacts on the terminals
  output logic input_term_one,
  output logic input_term_two,
  output logic input_term_three,
  output logic up_term,
  output logic down_term
);
  logic [4:0] seen_q, mask_q, raw_q, mask_d, raw_d;
  logic [2:0] n_q, n_d;
  always_comb begin
    mask_d = mask_q;
    n_d = n_q - {2'h0, n_q != 3'h0};
    if (want != seen_q) begin
      mask_d = want ^ seen_q;
      n_d = 3'h5;
    end
    // odd counts show the old level of the changed contacts
    raw_d = n_d[0] ? want ^ mask_d : want;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 5'h00;
      mask_q <= 5'h00;
      raw_q <= 5'h00;
      n_q <= 3'h0;
    end else begin
      seen_q <= want;
      mask_q <= mask_d;
      raw_q <= raw_d;
      n_q <= n_d;
    end
  end
  assign {down_term, up_term, input_term_three} = raw_q[4:2];
  assign {input_term_two, input_term_one} = raw_q[1:0];
endmodule // trc_operator
`default_nettype wire

// ---- testbench/trc_checker.sv ----
// assertions on the run command and filtered terminal outputs of trc_top
// bound into trc_top; one mclk domain
`timescale 1ns/1ns
`default_nettype none
module trc_checker (
  // clock, reset and watched ports
  input wire logic mclk,
  input wire logic resetn,
  input wire logic input_term_one,
  input wire logic [9:0] terminal_filter_time,
  input wire trc_pkg::trc_scheme_t terminal_scheme_select,
  input wire logic [4:0] filtered_terms,
  input wire logic forward_run_cmd,
  input wire logic reverse_run_cmd
);
  import trc_pkg::*;
  wire [4:0] t = filtered_terms;
  wire f = forward_run_cmd;
  wire r = reverse_run_cmd;
  trc_scheme_t s;
  assign s = terminal_scheme_select;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_fixed(trc_scheme_t m);
    s == m && $stable(s);
  endsequence
  sequence s_press(bit b);
    t[2] && $rose(t[b]) && !$rose(t[!b]);
  endsequence
  a_never_both: assert property (!(f && r))
    else $error("both run commands high");
  a_two_a: assert property (s_fixed(TRC_TWO_WIRE_A) |->
    f == (t[0] && !t[1]) && r == (t[1] && !t[0])) else $error("2wA decode");
  a_two_b: assert property (s_fixed(TRC_TWO_WIRE_B) |->
    f == (t[0] && !t[1]) && r == (t[0] && t[1])) else $error("2wB decode");
  a_enable_stops: assert property (s[1] && $stable(s) && !t[2] |->
    !f && !r) else $error("run without enable");
  a_press_fwd: assert property (s_fixed(TRC_THREE_WIRE_A) ##0
    s_press(1'b0) |-> f) else $error("forward press lost");
  a_press_rev: assert property (s_fixed(TRC_THREE_WIRE_A) ##0
    s_press(1'b1) |-> r) else $error("reverse press lost");
  a_state_held: assert property (s_fixed(TRC_THREE_WIRE_A) ##0
    t[2] && !$rose(t[0]) && !$rose(t[1]) |-> $stable({f, r}))
    else $error("3wA state changed without press");
  a_run_press: assert property (s_fixed(TRC_THREE_WIRE_B) ##0
    t[2] && $rose(t[0]) |-> f || r) else $error("3wB press lost");
  a_dir_level: assert property (s_fixed(TRC_THREE_WIRE_B) ##0
    (f || r) |-> r == t[1]) else $error("3wB direction");
  a_filter_wait: assert property ($changed(t[0]) &&
    terminal_filter_time != 10'h000 |-> $past(input_term_one, 2) == t[0]
    && $past(input_term_one, 9) == t[0]) else $error("filter too quick");
endmodule // trc_checker
bind trc_top trc_checker i_trc_checker (.*);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the terminal run command decoder
// contacts pass through the operator model; filter tick shortened
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import trc_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] want = 5'h00;
  logic input_term_one, input_term_two, input_term_three, up_term, down_term;
  logic [9:0] terminal_filter_time = 10'h002;
  trc_scheme_t terminal_scheme_select = SCHEME_DFLT;
  logic [15:0] updown_rate = 16'hC350;
  logic [1:0] freq_resolution_select = RES_CENTI;
  logic [19:0] updown_limit = 20'hFFFFF;
  logic [10:0] analog_input_one = 11'h1F4;
  logic analog_is_current = 1'b0;
  logic [9:0] curve_min_input = CURVE_MIN_IN_DFLT;
  logic [9:0] curve_max_input = CURVE_MAX_IN_DFLT;
  logic signed [10:0] curve_min_setting = CURVE_MIN_SET_DFLT;
  logic signed [10:0] curve_max_setting = CURVE_MAX_SET_DFLT;
  logic [3:0] below_min_handling = BELOW_MIN_USE_MIN;
  logic [4:0] filtered_terms;
  logic forward_run_cmd, reverse_run_cmd;
  logic [19:0] updown_freq;
  logic signed [10:0] analog_setting;
  // {three-wire B, want three/two/one, expected fwd/rev}
  logic [5:0] tab [13] = '{6'h10, 6'h16, 6'h12, 6'h19, 6'h08, 6'h0C,
    6'h30, 6'h36, 6'h32, 6'h39, 6'h32, 6'h20, 6'h24};
  int mismatches = 0, checks = 0, seed = 36, cyc = 0;
  always #5 mclk = ~mclk;
  trc_operator i_trc_operator (.*);
  trc_top #(.TICK_CYCLES(10)) i_trc_top (.*);
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction
  function automatic logic [19:0] runs();
    return {18'h0, forward_run_cmd, reverse_run_cmd};
  endfunction
  function automatic logic signed [10:0] exp_an();
    int v, lo, hi;
    v = analog_is_current ? analog_input_one >> 1 : analog_input_one;
    lo = int'(curve_min_input);
    hi = int'(curve_max_input);
    if (v > hi || hi <= lo) return curve_max_setting;
    if (v < lo) return below_min_handling == 4'h1 ? 11'sh000 : curve_min_setting;
    return 11'(int'(curve_min_setting) + (v - lo) * (int'(curve_max_setting)
      - int'(curve_min_setting)) / (hi - lo));
  endfunction
  task automatic chk(input string nm, input logic [19:0] e,
      input logic [19:0] g, input logic [19:0] tol = 20'h0);
    checks++;
    if ((g + tol >= e && g <= e + tol) !== 1'b1) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic hold(input logic [4:0] w);
    @(posedge mclk);
    want <= w;
    step(terminal_filter_time * 10 + 20);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    step(60);
    chk("an0", 20'h001F4, 20'(analog_setting));
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        @(posedge mclk);
        terminal_scheme_select <= trc_scheme_t'(s);
        terminal_filter_time <= 10'(1 + rnd(3));
        hold(5'(p));
        chk("r2", {18'h0, p[0] & !p[1], p[1] & (p[0] == s[0])}, runs());
        chk("ft", 20'(p), 20'(filtered_terms));
      end
    end
    @(posedge mclk);
    terminal_filter_time <= 10'h003;
    want <= 5'h01;
    step(12);
    chk("early", 20'h0, runs() >> 1);
    step(40);
    chk("late", 20'h1, runs() >> 1);
    for (int i = 0; i < 13; i++) begin
      @(posedge mclk);
      terminal_scheme_select <= tab[i][5] ? TRC_THREE_WIRE_B : TRC_THREE_WIRE_A;
      hold(5'(tab[i][4:2]));
      chk("r3", 20'(tab[i][1:0]), runs());
    end
    for (int i = 0; i < 24; i++) begin
      @(posedge mclk);
      analog_is_current <= i[1];
      analog_input_one <= 11'(rnd(i[1] ? 2001 : 1001));
      curve_min_input <= 10'(rnd(600));
      curve_max_input <= 10'(600 + rnd(401));
      curve_min_setting <= 11'(rnd(2001) - 1000);
      curve_max_setting <= 11'(rnd(2001) - 1000);
      below_min_handling <= i[0] ? BELOW_MIN_USE_ZERO : 4'(rnd(10));
      step(60);
      chk("an", 20'(exp_an()), 20'(analog_setting));
    end
    @(posedge mclk);
    want <= 5'h08;
    step(15000);
    chk("upc", 20'(15000 * 50000 / 100000000 * 10), updown_freq, 20'hA);
    @(posedge mclk);
    want <= 5'h10;
    step(20000);
    chk("dn", 20'h0, updown_freq);
    @(posedge mclk);
    freq_resolution_select <= RES_MILLI;
    want <= 5'h08;
    step(15000);
    chk("upm", 20'(15000 * 50000 / 100000000), updown_freq, 20'h1);
    @(posedge mclk);
    updown_limit <= 20'h3;
    step(15000);
    chk("lim", 20'h3, updown_freq);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
